//--- bsc_chain.sv
// tap controller with identification and boundary scan data registers
`timescale 1ns/1ps
module bsc_chain #(
    parameter logic [3:0]  ID_VERSION = 4'h3,    // arbitrary value
    parameter logic [15:0] ID_PART    = 16'h2c5a, // arbitrary value
    parameter logic [10:0] ID_MAKER   = 11'h0a6  // arbitrary value
) (
    input  wire logic                      clk,       // system clock, 200 MHz
    input  wire logic                      reset,     // power-on reset, synchronous
    input  wire bsc_pkg::bsc_tap_pins_type tap_pins,  // tck, tms, tdi, trst_n pins
    output logic                           tdo,       // serial out, falls with tck
    output logic                           tdo_en,    // high while shifting
    input  wire bsc_pkg::bsc_drive_type    core_drive, // functional level and enable
    input  wire [bsc_pkg::CHAIN_LEN-1:0]   pad_in,    // levels seen at the pads
    output bsc_pkg::bsc_drive_type         pad_drive  // level and enable to the pads
);

    localparam int N = bsc_pkg::CHAIN_LEN;

    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
        SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
    } bsc_tap_state_type;

    bsc_pkg::bsc_tap_pins_type tap_s;
    logic [N-1:0]              pad_in_s;
    logic                      tck_prev_r;
    logic                      tck_rise;
    logic                      tck_fall;
    bsc_tap_state_type         state_r;
    bsc_tap_state_type         state_nxt;
    logic [bsc_pkg::IR_LEN-1:0] ir_r;
    logic [bsc_pkg::IR_LEN-1:0] ir_shift_r;
    logic [bsc_pkg::ID_LEN-1:0] id_shift_r;
    logic [bsc_pkg::ID_LEN-1:0] id_value;
    logic [N-1:0]              bsr_shift_r;
    logic [N-1:0]              bsr_update_r;
    logic [N-1:0]              capture_bits;
    logic                      bypass_r;
    logic                      dr_out;
    logic                      extest;
    bsc_pkg::bsc_select_type   sel;
    bsc_pkg::bsc_drive_type    drive_nxt;

    // test pins and pad inputs come from outside the clk domain
    bsc_sync #(
        .WIDTH ($bits(bsc_pkg::bsc_tap_pins_type))
    ) u_tap_sync (
        .clk      (clk),
        .reset    (reset),
        .async_in (tap_pins),
        .sync_out (tap_s)
    );

    bsc_sync #(
        .WIDTH (N)
    ) u_pad_sync (
        .clk      (clk),
        .reset    (reset),
        .async_in (pad_in),
        .sync_out (pad_in_s)
    );

    // tck edges found by sampling; tms and tdi share its delay so they stay aligned
    always_ff @(posedge clk) begin
        if (reset)
            tck_prev_r <= 1'b0;
        else
            tck_prev_r <= tap_s.tck;
    end

    assign tck_rise = tap_s.tck & ~tck_prev_r;
    assign tck_fall = ~tap_s.tck & tck_prev_r;

    // standard sixteen-state walk steered by tms
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            TLR:    state_nxt = tap_s.tms ? TLR    : RTI;
            RTI:    state_nxt = tap_s.tms ? SEL_DR : RTI;
            SEL_DR: state_nxt = tap_s.tms ? SEL_IR : CAP_DR;
            CAP_DR: state_nxt = tap_s.tms ? EX1_DR : SH_DR;
            SH_DR:  state_nxt = tap_s.tms ? EX1_DR : SH_DR;
            EX1_DR: state_nxt = tap_s.tms ? UPD_DR : PAU_DR;
            PAU_DR: state_nxt = tap_s.tms ? EX2_DR : PAU_DR;
            EX2_DR: state_nxt = tap_s.tms ? UPD_DR : SH_DR;
            UPD_DR: state_nxt = tap_s.tms ? SEL_DR : RTI;
            SEL_IR: state_nxt = tap_s.tms ? TLR    : CAP_IR;
            CAP_IR: state_nxt = tap_s.tms ? EX1_IR : SH_IR;
            SH_IR:  state_nxt = tap_s.tms ? EX1_IR : SH_IR;
            EX1_IR: state_nxt = tap_s.tms ? UPD_IR : PAU_IR;
            PAU_IR: state_nxt = tap_s.tms ? EX2_IR : PAU_IR;
            EX2_IR: state_nxt = tap_s.tms ? UPD_IR : SH_IR;
            UPD_IR: state_nxt = tap_s.tms ? SEL_DR : RTI;
        endcase
    end

    // power-on reset or the test reset pin forces test logic reset
    always_ff @(posedge clk) begin
        if (reset || !tap_s.trst_n)
            state_r <= TLR;
        else if (tck_rise)
            state_r <= state_nxt;
    end

    // instruction register: capture pattern, shift, update on falling tck
    always_ff @(posedge clk) begin
        if (reset || !tap_s.trst_n || state_r == TLR) begin
            ir_shift_r <= bsc_pkg::IR_CAPTURE;
            ir_r       <= bsc_pkg::OP_IDCODE;
        end else begin
            if (tck_rise && state_r == CAP_IR)
                ir_shift_r <= bsc_pkg::IR_CAPTURE;
            else if (tck_rise && state_r == SH_IR)
                ir_shift_r <= {tap_s.tdi, ir_shift_r[bsc_pkg::IR_LEN-1:1]};
            if (tck_fall && state_r == UPD_IR)
                ir_r <= ir_shift_r;
        end
    end

    assign sel    = bsc_pkg::select_of(ir_r);
    assign extest = (ir_r == bsc_pkg::OP_EXTEST);

    // identification word is built from constants only
    always_comb begin
        id_value = '0;
        id_value[bsc_pkg::ID_VER_MSB:bsc_pkg::ID_VER_LSB]   = ID_VERSION;
        id_value[bsc_pkg::ID_PART_MSB:bsc_pkg::ID_PART_LSB] = ID_PART;
        id_value[bsc_pkg::ID_MFR_MSB:bsc_pkg::ID_MFR_LSB]   = ID_MAKER;
        id_value[bsc_pkg::ID_ONE_BIT]                       = bsc_pkg::ID_ONE_VALUE;
    end

    // id shifter reloads on every capture so shifted-in data never sticks
    always_ff @(posedge clk) begin
        if (reset)
            id_shift_r <= '0;
        else if (tck_rise && state_r == CAP_DR && sel == bsc_pkg::SEL_ID)
            id_shift_r <= id_value;
        else if (tck_rise && state_r == SH_DR && sel == bsc_pkg::SEL_ID)
            id_shift_r <= {tap_s.tdi, id_shift_r[bsc_pkg::ID_LEN-1:1]};
    end

    // bypass bit captures zero as usual
    always_ff @(posedge clk) begin
        if (reset)
            bypass_r <= 1'b0;
        else if (tck_rise && state_r == CAP_DR && sel == bsc_pkg::SEL_BYPASS)
            bypass_r <= 1'b0;
        else if (tck_rise && state_r == SH_DR && sel == bsc_pkg::SEL_BYPASS)
            bypass_r <= tap_s.tdi;
    end

    // per-cell capture source and pad drive, decided by the cell kind
    generate
        for (genvar i = 0; i < N; i++) begin : g_cell
            localparam bsc_pkg::bsc_cell_kind_type KIND = bsc_pkg::cell_kind(i);
            localparam int CTRL = bsc_pkg::ctrl_cell(i);
            if (KIND == bsc_pkg::CK_INPUT) begin : g_in
                assign capture_bits[i]     = pad_in_s[i];
                assign drive_nxt.level[i]  = core_drive.level[i];
                assign drive_nxt.enable[i] = extest ? 1'b0 : core_drive.enable[i];
            end else if (KIND == bsc_pkg::CK_OUT2) begin : g_out
                assign capture_bits[i]     = core_drive.level[i];
                assign drive_nxt.level[i]  = extest ? bsr_update_r[i] : core_drive.level[i];
                assign drive_nxt.enable[i] = extest ? 1'b1 : core_drive.enable[i];
            end else if (KIND == bsc_pkg::CK_BIDIR) begin : g_bidir
                assign capture_bits[i]     = pad_in_s[i];
                assign drive_nxt.level[i]  = extest ? bsr_update_r[i] : core_drive.level[i];
                assign drive_nxt.enable[i] = extest ? bsr_update_r[CTRL]
                                                    : core_drive.enable[i];
            end else begin : g_aux
                // control and internal cells have no pad; the core level passes untouched, the enable is forced off in extest
                assign capture_bits[i]     = (KIND == bsc_pkg::CK_CONTROL)
                                             ? core_drive.enable[i] : core_drive.level[i];
                assign drive_nxt.level[i]  = core_drive.level[i];
                assign drive_nxt.enable[i] = extest ? 1'b0 : core_drive.enable[i];
            end
        end
    endgenerate

    // chain shifter: cell 56 next to tdi, cell 0 next to tdo
    always_ff @(posedge clk) begin
        if (reset)
            bsr_shift_r <= '0;
        else if (tck_rise && state_r == CAP_DR && sel == bsc_pkg::SEL_BSR)
            bsr_shift_r <= capture_bits;
        else if (tck_rise && state_r == SH_DR && sel == bsc_pkg::SEL_BSR)
            bsr_shift_r <= {tap_s.tdi, bsr_shift_r[N-1:1]};
    end

    // update latch moves on falling tck so pins never see the shifting bits
    always_ff @(posedge clk) begin
        if (reset || !tap_s.trst_n || state_r == TLR)
            bsr_update_r <= '0;
        else if (tck_fall && state_r == UPD_DR && sel == bsc_pkg::SEL_BSR)
            bsr_update_r <= bsr_shift_r;
    end

    always_comb begin
        unique case (sel)
            bsc_pkg::SEL_BSR: dr_out = bsr_shift_r[0];
            bsc_pkg::SEL_ID:  dr_out = id_shift_r[0];
            default:          dr_out = bypass_r;
        endcase
    end

    // tdo changes on falling tck, giving the tester half a period of setup
    always_ff @(posedge clk) begin
        if (reset) begin
            tdo    <= 1'b0;
            tdo_en <= 1'b0;
        end else if (tck_fall) begin
            tdo    <= (state_r == SH_IR) ? ir_shift_r[0] : dr_out;
            tdo_en <= (state_r == SH_IR) || (state_r == SH_DR);
        end
    end

    // pads follow the core unless extest; the register costs one clk of latency
    always_ff @(posedge clk) begin
        if (reset)
            pad_drive <= '0;
        else
            pad_drive <= drive_nxt;
    end

endmodule

//--- bsc_chain_asserts.sv
// concurrent checks on the ports of the boundary scan chain
`timescale 1ns/1ps
module bsc_chain_asserts (
    input  wire logic                      clk,        // system clock
    input  wire logic                      reset,      // sync reset
    input  wire bsc_pkg::bsc_tap_pins_type tap_pins,   // test pins
    input  wire logic                      tdo,        // serial out
    input  wire logic                      tdo_en,     // serial out enable
    input  wire bsc_pkg::bsc_drive_type    core_drive, // functional drive
    input  wire [bsc_pkg::CHAIN_LEN-1:0]   pad_in,     // pad levels
    input  wire bsc_pkg::bsc_drive_type    pad_drive   // drive to pads
);
    localparam logic [56:0] OUT2  = 57'h0400_0000_0000_007;
    localparam logic [56:0] NODRV = 57'h12a7_9055_5501_038;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // pads off the core path: only the update latch may cause that
    sequence s_latched;
        !$past(reset) && !$past(reset, 2) && pad_drive != $past(core_drive);
    endsequence
    property p_reset_quiet;
        $fell(reset) |-> !tdo && !tdo_en && pad_drive == '0;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy at reset");
    property p_tdo_at_fall;
        $changed(tdo) |-> !tap_pins.tck && !$past(tap_pins.tck, 2);
    endproperty
    a_tdo_at_fall: assert property (p_tdo_at_fall) else $error("tdo moved off a fall");
    property p_tdo_en_at_fall;
        $changed(tdo_en) |-> !tap_pins.tck && !$past(tap_pins.tck, 2);
    endproperty
    a_tdo_en_at_fall: assert property (p_tdo_en_at_fall) else $error("tdo_en off a fall");
    property p_rise_quiet;
        $rose(tap_pins.tck) |=> $stable(tdo) [*4];
    endproperty
    a_rise_quiet: assert property (p_rise_quiet) else $error("tdo moved after a rise");
    property p_follow_trst;
        !tap_pins.trst_n [*6] |=> pad_drive == $past(core_drive);
    endproperty
    a_follow_trst: assert property (p_follow_trst) else $error("pads off core in reset");
    property p_quiet_trst;
        !tap_pins.trst_n [*6] |-> !tdo_en;
    endproperty
    a_quiet_trst: assert property (p_quiet_trst) else $error("tdo_en in test reset");
    property p_extest_out2;
        s_latched |-> (pad_drive.enable & OUT2) == OUT2;
    endproperty
    a_extest_out2: assert property (p_extest_out2) else $error("output cell undriven");
    property p_extest_nodrive;
        s_latched |-> (pad_drive.enable & NODRV) == '0;
    endproperty
    a_extest_nodrive: assert property (p_extest_nodrive) else $error("non-pin cell drives");
    property p_enter_at_fall;
        s_latched and $past(pad_drive) == $past(core_drive, 2) |-> !tap_pins.tck;
    endproperty
    a_enter_at_fall: assert property (p_enter_at_fall) else $error("update off a fall");
    c_shift: cover property ($rose(tdo_en));
    c_extest: cover property (s_latched);
    c_trst: cover property ($fell(tap_pins.trst_n));
endmodule

bind bsc_chain bsc_chain_asserts u_chk (.clk(clk), .reset(reset), .tap_pins(tap_pins),
    .tdo(tdo), .tdo_en(tdo_en), .core_drive(core_drive), .pad_in(pad_in),
    .pad_drive(pad_drive));

//--- bsc_jtag_host.sv
// board test controller driving the test pins
`timescale 1ns/1ps
module bsc_jtag_host (
    input  wire logic          clk,  // bench clock, pins move at its fall
    output bsc_pkg::bsc_tap_pins_type pins, // tck, tms, tdi, trst_n
    input  wire logic          tdo   // serial answer
);
    localparam int HALF = 16; // 80 ns high, 85 ns low, 165 ns period
    logic last_tdi;
    // tck rests low between frames
    initial begin
        pins = '{1'b0, 1'b1, 1'b0, 1'b1};
        last_tdi = 1'b0;
    end
    // one tck period; tdo is taken just before the rise, where it stood since the fall
    task automatic bit_cycle(input logic tms, input logic tdi, output logic tdo_s);
        @(negedge clk);
        pins.tms = tms;
        pins.tdi = tdi;
        last_tdi = tdi;
        repeat (HALF) @(negedge clk);
        tdo_s = tdo;
        pins.tck = 1'b1;
        repeat (HALF) @(negedge clk);
        pins.tck = 1'b0;
    endtask
    // state step outside shifting: tdi toggles so stale data never looks valid
    task automatic move(input logic tms);
        logic d;
        bit_cycle(tms, ~last_tdi, d);
    endtask
    // idle to idle scan of n bits, lsb first
    task automatic scan(input logic ir, input int n, input logic [63:0] din,
                        output logic [63:0] dout);
        logic d;
        dout = '0;
        move(1'b1);
        if (ir)
            move(1'b1);
        move(1'b0);
        move(1'b0);
        for (int k = 0; k < n; k++) begin
            bit_cycle(k == n - 1, din[k], d);
            dout[k] = d;
        end
        move(1'b1);
        move(1'b0);
    endtask
    task automatic set_trst(input logic v);
        @(negedge clk);
        pins.trst_n = v;
    endtask
endmodule

//--- bsc_pkg.sv
// shared constants, types and cell decoding for the boundary scan chain block
package bsc_pkg;

    // chain geometry and register widths
    localparam int CHAIN_LEN = 57;
    localparam int ID_LEN    = 32;
    localparam int IR_LEN    = 5;

    // identification register field positions
    localparam int ID_VER_MSB  = 31;
    localparam int ID_VER_LSB  = 28;
    localparam int ID_PART_MSB = 27;
    localparam int ID_PART_LSB = 12;
    localparam int ID_MFR_MSB  = 11;
    localparam int ID_MFR_LSB  = 1;
    localparam int ID_ONE_BIT  = 0;
    localparam logic ID_ONE_VALUE = 1'b1;

    // instruction opcodes
    localparam logic [IR_LEN-1:0] OP_EXTEST  = 5'h00;
    localparam logic [IR_LEN-1:0] OP_SAMPLE  = 5'h01;
    localparam logic [IR_LEN-1:0] OP_IDCODE  = 5'h0c;
    localparam logic [IR_LEN-1:0] OP_BYPASS  = 5'h1f;
    localparam logic [IR_LEN-1:0] IR_CAPTURE = 5'h01;

    // named cells of the chain
    localparam int CELL_DOWNSTREAM_PORT_RESET_OUT_FIRST = 0;
    localparam int CELL_DOWNSTREAM_PORT_RESET_OUT_LAST  = 2;
    localparam int CELL_FUNDAMENTAL_RESET_IN            = 4;
    localparam int CELL_CTRL_LOW_BANK                   = 12;
    localparam int CELL_CTRL_HIGH_BANK                  = 45;
    localparam int CELL_CLOCK_BUFFER_POWERDOWN          = 47;
    localparam int CELL_CLOCK_REQUEST_PIN_FIRST         = 48;
    localparam int CELL_CLOCK_REQUEST_PIN_LAST          = 53;
    localparam int CELL_SERIAL_ROM_CLOCK                = 54;
    localparam int CELL_SERIAL_ROM_DATA                 = 55;
    localparam int GPIO_FIRST                           = 19;
    localparam int GPIO_LAST                            = 34;
    localparam int CELL_CTRL_LAST                       = 56;

    typedef enum logic [2:0] {
        CK_OUT2,
        CK_INPUT,
        CK_BIDIR,
        CK_CONTROL,
        CK_INTERNAL
    } bsc_cell_kind_type;

    typedef enum logic [1:0] {
        SEL_BSR,
        SEL_ID,
        SEL_BYPASS
    } bsc_select_type;

    // level and enable of every chain position travel together
    typedef struct packed {
        logic [CHAIN_LEN-1:0] level;
        logic [CHAIN_LEN-1:0] enable;
    } bsc_drive_type;

    // serial test pins as seen from the pads
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
        logic trst_n;
    } bsc_tap_pins_type;

    // kind of cell at each chain position
    function automatic bsc_cell_kind_type cell_kind(input int i);
        if (i <= CELL_DOWNSTREAM_PORT_RESET_OUT_LAST || i == CELL_SERIAL_ROM_CLOCK)
            return CK_OUT2;
        if (i == 3 || i == CELL_FUNDAMENTAL_RESET_IN || i == 5)
            return CK_INPUT;
        if (i == 40 || i == 43 || i == 44 || i == 46)
            return CK_INTERNAL;
        if (i == CELL_CTRL_LOW_BANK || i == CELL_CTRL_HIGH_BANK || i == CELL_CTRL_LAST)
            return CK_CONTROL;
        // general-purpose pins sit on odd positions, their controls just above them
        if (i >= GPIO_FIRST && i <= GPIO_LAST && (i % 2) == 0)
            return CK_CONTROL;
        // clock request pins start on an even position, so their controls are odd
        if (i > CELL_CLOCK_REQUEST_PIN_FIRST && i <= CELL_CLOCK_REQUEST_PIN_LAST
            && (i % 2) == 1)
            return CK_CONTROL;
        return CK_BIDIR;
    endfunction

    // control cell that governs a bidirectional cell
    function automatic int ctrl_cell(input int i);
        if (i < GPIO_FIRST)
            return CELL_CTRL_LOW_BANK;
        if (i > GPIO_LAST && i < CELL_CLOCK_REQUEST_PIN_FIRST)
            return CELL_CTRL_HIGH_BANK;
        return i + 1;
    endfunction

    // data register chosen by an instruction, unlisted codes act as bypass
    function automatic bsc_select_type select_of(input logic [IR_LEN-1:0] op);
        if (op == OP_EXTEST || op == OP_SAMPLE)
            return SEL_BSR;
        if (op == OP_IDCODE)
            return SEL_ID;
        return SEL_BYPASS;
    endfunction

endpackage

//--- bsc_sync.sv
// two-stage synchroniser for levels entering the clk domain
`timescale 1ns/1ps
module bsc_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,      // system clock
    input  wire logic             reset,    // synchronous, active high
    input  wire logic [WIDTH-1:0] async_in, // level from outside the domain
    output logic      [WIDTH-1:0] sync_out  // level safe to use
);

    logic [WIDTH-1:0] meta_r;

    // first stage is read only by the second stage
    always_ff @(posedge clk) begin
        if (reset) begin
            meta_r   <= '0;
            sync_out <= '0;
        end else begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end

endmodule

//--- tb.sv
// self-checking bench for the boundary scan chain
`timescale 1ns/1ps
module tb;
    localparam logic [3:0]  VER   = 4'h9;     // arbitrary value
    localparam logic [15:0] PART  = 16'h1b3d; // arbitrary value
    localparam logic [10:0] MAKER = 11'h155;  // arbitrary value
    localparam logic [63:0] ID_W  = {32'h0, VER, PART, MAKER, 1'b1};
    localparam logic [56:0] CTL   = 57'h12a2_0055_5501_000;
    localparam logic [56:0] INTL  = 57'h0005_9000_0000_000;
    localparam logic [56:0] OUT2  = 57'h0400_0000_0000_007;
    localparam logic [56:0] INP   = 57'h0000_0000_0000_038;
    localparam logic [56:0] BID   = ~(CTL | INTL | OUT2 | INP);
    localparam logic [4:0]  BYP [4] = '{5'h1f, 5'h05, 5'h04, 5'h13};
    logic                      clk;
    logic                      reset;
    logic                      tdo;
    logic                      tdo_en;
    logic [56:0]               pad_in;
    logic [56:0]               pre;
    logic [63:0]               got;
    bsc_pkg::bsc_tap_pins_type pins;
    bsc_pkg::bsc_drive_type    core;
    bsc_pkg::bsc_drive_type    pads;
    int                        bad_count;
    int                        check_count;
    bsc_chain #(.ID_VERSION(VER), .ID_PART(PART), .ID_MAKER(MAKER)) DUT (
        .clk(clk), .reset(reset), .tap_pins(pins), .tdo(tdo), .tdo_en(tdo_en),
        .core_drive(core), .pad_in(pad_in), .pad_drive(pads));
    bsc_jtag_host host (.clk(clk), .pins(pins), .tdo(tdo));
    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    function automatic logic [56:0] rnd57();
        return 57'({$urandom, $urandom});
    endfunction
    // capture: pins for input and bidir cells, core level or enable for the rest
    function automatic logic [56:0] cap_exp();
        return (pad_in & (INP | BID)) | (core.level & (INTL | OUT2)) | (core.enable & CTL);
    endfunction
    // each bidir cell is enabled by its control cell, output-only cells always
    function automatic logic [56:0] en_exp(input logic [56:0] u);
        logic [56:0] e;
        e = OUT2;
        for (int i = 0; i < 57; i++)
            if (BID[i])
                e[i] = u[(i < 19) ? 12 : (i > 34 && i < 48) ? 45 : i + 1];
        return e;
    endfunction
    task automatic cmp(input logic [63:0] g, input logic [63:0] e, input logic [63:0] m);
        check_count++;
        if ((g & m) !== (e & m)) begin
            bad_count++;
            $display("MISMATCH %0t serial word %h expected %h", $time, g & m, e & m);
        end
    endtask
    task automatic cmp_pad(input logic [56:0] lvl, input logic [56:0] en, input logic [56:0] m);
        check_count++;
        if ((pads.level & m) !== (lvl & m) || pads.enable !== en) begin
            bad_count++;
            $display("MISMATCH %0t pad drive %h enable %h", $time, pads.level, pads.enable);
        end
    endtask
    task automatic end_sim();
        if (bad_count == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // identification read with random data pushed in behind it
    task automatic read_id();
        host.scan(1'b0, 32, {$urandom, $urandom}, got);
        cmp(got, ID_W, 64'hffff_f000);
        cmp(got, ID_W, 64'h0000_0ffe);
        cmp(got, ID_W, 64'h0000_0001);
        cmp({63'h0, tdo_en}, 64'h0, 64'h1);
    endtask
    task automatic load(input logic [4:0] op);
        host.scan(1'b1, 5, {59'h0, op}, got);
    endtask
    task automatic bsr(input logic [56:0] d);
        host.scan(1'b0, 57, {7'h0, d}, got);
        cmp(got, {7'h0, cap_exp()}, {7'h0, {57{1'b1}}});
    endtask
    // new pad and core values, given time to pass the pad synchronisers
    task automatic new_pins();
        @(negedge clk);
        core.level = rnd57();
        core.enable = rnd57();
        pad_in = rnd57();
        repeat (4) @(negedge clk);
    endtask
    // watchdog, several times the expected run
    initial begin
        repeat (80000) @(posedge clk);
        bad_count++;
        end_sim();
    end
    // main sequence
    initial begin
        void'($urandom(32'h4f18));
        reset = 1'b1;
        core = '0;
        pad_in = '0;
        bad_count = 0;
        check_count = 0;
        repeat (20) @(posedge clk);
        @(negedge clk);
        reset = 1'b0;
        repeat (8) @(negedge clk);
        host.move(1'b0);
        read_id();
        read_id();
        host.scan(1'b1, 5, {59'h0, bsc_pkg::OP_IDCODE}, got);
        cmp(got, 64'(bsc_pkg::IR_CAPTURE), 64'h1f);
        read_id();
        new_pins();
        load(bsc_pkg::OP_SAMPLE);
        pre = rnd57();
        bsr(pre);
        cmp_pad(core.level, core.enable, '1);
        // extest with a random word, then its complement so every cell flips
        load(bsc_pkg::OP_EXTEST);
        for (int k = 0; k < 2; k++) begin
            repeat (8) @(negedge clk);
            cmp_pad(pre, en_exp(pre), BID | OUT2);
            new_pins();
            cmp_pad(pre, en_exp(pre), BID | OUT2);
            pre = ~pre;
            bsr(pre);
        end
        // bypass and codes that fall back to it: one cell, captured as zero
        foreach (BYP[i]) begin
            load(BYP[i]);
            pre = rnd57();
            host.scan(1'b0, 8, {56'h0, pre[7:0]}, got);
            cmp(got, {56'h0, pre[6:0], 1'b0}, 64'hff);
        end
        cmp_pad(core.level, core.enable, '1);
        // test reset pin while extest drives the pads
        load(bsc_pkg::OP_EXTEST);
        host.set_trst(1'b0);
        repeat (10) @(negedge clk);
        cmp_pad(core.level, core.enable, '1);
        host.set_trst(1'b1);
        host.move(1'b0);
        read_id();
        // power-on reset in mid-run, extest loaded again
        load(bsc_pkg::OP_EXTEST);
        reset = 1'b1;
        repeat (3) @(negedge clk);
        cmp_pad('0, '0, '1);
        reset = 1'b0;
        repeat (8) @(negedge clk);
        host.move(1'b0);
        read_id();
        end_sim();
    end
endmodule
